// >>> tb/rtbp_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// backend memory model
// ****************************************************************
module rtbp_mem_model
  import rtbp_pkg::*;
(
  // clock, mode and stall count
  input  wire logic              clk,
  input  wire logic              sync_mode,
  input  wire logic [7:0]        stall,
  // memory pins
  input  wire logic              select_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic [DATA_W-1:0] write_word,
  output wire logic [DATA_W-1:0] read_word,
  output wire logic              wait_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] q_r   = 16'h5a5a;
  logic [7:0]        cnt_r = 8'h00;
  wire  logic        strobe;

  assign strobe    = !select_n && !(read_strobe_n && write_strobe_n);
  // async mode only: not ready for the first stall cycles of each strobe
  assign wait_n    = sync_mode || !strobe || (cnt_r >= stall);
  assign read_word = (!sync_mode && strobe && !read_strobe_n) ? mem[address] : q_r;

  always_ff @(posedge clk)
  begin
    cnt_r <= strobe ? cnt_r + 8'h01 : 8'h00;
    if (strobe && !write_strobe_n)
      mem[address] <= write_word;
    // without a read strobe the held word is inverted every clock
    q_r <= (strobe && !read_strobe_n) ? mem[address] : ~q_r;
  end
endmodule : rtbp_mem_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import rtbp_pkg::*;
  logic              CLK = 0, RST = 1, SYNC_MODE = 0, REQ_VALID = 0, REQ_WRITE = 0;
  logic [KIND_W-1:0] REQ_KIND = 0;
  logic [ADDR_W-1:0] REQ_ADDR = 0;
  logic [DATA_W-1:0] REQ_DATA = 0;
  logic [7:0]        stall = 0;
  wire  logic        REQ_READY, RD_VALID, BUSY, SEL_N, RD_N, WR_N, WAIT_N;
  wire  logic [KIND_W-1:0] KIND;
  wire  logic [ADDR_W-1:0] ADDR;
  wire  logic [DATA_W-1:0] RD_DATA, WWORD, RWORD;
  int                error_cnt = 0, checks = 0;
  logic              p_sel = 1, p_rd = 1;
  logic [ADDR_W-1:0] p_addr = 0;

  rtbp_memport rtbp_memport_inst (.CLK(CLK), .RST(RST), .SYNC_MODE(SYNC_MODE),
    .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE),
    .REQ_KIND(REQ_KIND), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID), .BUSY(BUSY), .BACKEND_SELECT_N(SEL_N), .BACKEND_READ_STROBE_N(RD_N),
    .BACKEND_WRITE_STROBE_N(WR_N), .ACCESS_KIND_CODE(KIND), .BACKEND_ADDRESS(ADDR),
    .BACKEND_WRITE_WORD(WWORD), .BACKEND_READ_WORD(RWORD), .BACKEND_WAIT_N(WAIT_N));
  rtbp_mem_model rtbp_mem_model_inst (.clk(CLK), .sync_mode(SYNC_MODE), .stall(stall),
    .select_n(SEL_N), .read_strobe_n(RD_N), .write_strobe_n(WR_N), .address(ADDR),
    .write_word(WWORD), .read_word(RWORD), .wait_n(WAIT_N));

  initial
  begin
    forever #10 CLK = ~CLK;
  end

  task automatic results();
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ****************************************************************
  // pin watcher
  // ****************************************************************
  always @(negedge CLK)
  begin
    if (!RST)
    begin
      if (!(RD_N && WR_N)) chk("select_in_strobe", SEL_N, 0);
      if (!SEL_N && !p_sel) chk("address_frame", ADDR, p_addr);
      if (!SEL_N) chk("kind_unused", KIND == KIND_UNUSED, 0);
      if (p_rd && !RD_N) chk("select_lead", p_sel, SYNC_MODE);
      if (!p_rd && RD_N && !SYNC_MODE) chk("select_trail", SEL_N, 0);
    end
    p_sel  <= SEL_N;
    p_rd   <= RD_N;
    p_addr <= ADDR;
  end

  // ****************************************************************
  // request helpers
  // ****************************************************************
  task automatic push(input logic w, input logic [1:0] k, input logic [10:0] a,
                      input logic [15:0] d);
    int n;
    n         = 0;
    REQ_VALID = 1;
    REQ_WRITE = w;
    REQ_KIND  = k;
    REQ_ADDR  = a;
    REQ_DATA  = d;
    while (REQ_READY !== 1'b1 && n < 200)
    begin
      @(negedge CLK);
      n++;
    end
    if (n == 200)
    begin
      chk("timeout", 1, 0);
      results();
    end
    @(negedge CLK);
    REQ_VALID = 0;
    // one idle edge so a following request never re-raises valid in this step
    @(negedge CLK);
  endtask : push

  task automatic access(input logic w, input logic [1:0] k, input logic [10:0] a,
                        input logic [15:0] d, input int mn,
                        output int lo, output int rv, output logic [28:0] pk);
    logic got;
    int   n;
    got = 0;
    lo  = 0;
    rv  = 0;
    pk  = 0;
    push(w, k, a, d);
    for (n = 0; n < 1000; n++)
    begin
      if (!(w ? WR_N : RD_N))
      begin
        got = 1;
        lo++;
        pk  = {KIND, ADDR, WWORD};
      end
      if (RD_VALID === 1'b1)
      begin
        rv++;
        pk[15:0] = RD_DATA;
      end
      if ((got || n >= mn) && !BUSY)
        break;
      @(negedge CLK);
    end
    if (n == 1000)
    begin
      chk("timeout", 1, 0);
      results();
    end
  endtask : access

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_mode(input logic sm, input logic [7:0] st);
    int          lo, rv;
    logic [28:0] pk, e;
    SYNC_MODE = sm;
    stall     = st;
    RST       = 1;
    repeat (5) @(negedge CLK);
    RST = 0;
    chk("reset_pins", {SEL_N, RD_N, WR_N, RD_VALID, REQ_READY, BUSY}, 6'h3a);
    chk("reset_bus", {KIND, ADDR, WWORD}, 0);
    for (int k = 0; k < 3; k++)
    begin
      e = {2'(k), 11'h7ff - 11'(k), 16'hc3a5 ^ 16'(k)};
      access(1, e[28:27], e[26:16], e[15:0], 8, lo, rv, pk);
      chk("wr_pins", pk, e);
      chk("wr_strobe_len", lo, sm ? 1 : 1 + st);
      access(0, e[28:27], e[26:16], 16'h0000, 8, lo, rv, pk);
      chk("rd_word", pk, e);
      chk("rd_strobe_len", lo, sm ? 1 : 1 + st);
      chk("rd_valid_cnt", rv, 1);
    end
    access(1, KIND_UNUSED, 11'h001, 16'hffff, 8, lo, rv, pk);
    chk("dropped_strobe", lo, 0);
  endtask : t_mode

  task automatic t_fill();
    int          lo, rv;
    logic [28:0] pk;
    logic        full;
    full  = 0;
    stall = 20;
    for (int i = 0; i < 20; i++)
    begin
      push(1, KIND_DATA, 11'(i), 16'(i) ^ 16'h5a00);
      if (!REQ_READY)
        full = 1;
    end
    chk("fifo_full", full, 1);
    access(0, KIND_DATA, 11'h013, 16'h0000, 2000, lo, rv, pk);
    chk("fifo_order", pk, {KIND_DATA, 11'h013, 16'h5a13});
    chk("fifo_drained", REQ_READY, 1);
  endtask : t_fill

  initial
  begin
    t_mode(0, 0);
    t_mode(0, 2);
    t_fill();
    t_mode(1, 3);
    results();
  end
endmodule : tb

// >>> verilog/rtbp_memport.sv
// Operation
// - select falls as the address is loaded, address held while select low
// - wait low stretches the asynchronous strobe
// - two-bit kind code, eleven never driven
// - eleven-bit address, sixteen-bit write word out
// - async strobe one clock plus wait cycles, address framed
// - sync strobe means capture next edge
`timescale 1ns/1ps

// ****************************************************************
// request fifo
// ****************************************************************
module rtbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      if (pop)
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      if (push && !pop)
        cnt_r <= cnt_r + CW'(1);
      else if (pop && !push)
        cnt_r <= cnt_r - CW'(1);
    end
  end
endmodule : rtbp_fifo

// ****************************************************************
// backend memory port
// ****************************************************************
module rtbp_memport
  import rtbp_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // static mode strap, high for synchronous memory
  input  wire logic              SYNC_MODE,
  // access requests
  input  wire logic              REQ_VALID,
  output wire logic              REQ_READY,
  input  wire logic              REQ_WRITE,
  input  wire logic [KIND_W-1:0] REQ_KIND,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_DATA,
  // read results and status
  output wire logic [DATA_W-1:0] RD_DATA,
  output wire logic              RD_VALID,
  output wire logic              BUSY,
  // backend memory pins
  output wire logic              BACKEND_SELECT_N,
  output wire logic              BACKEND_READ_STROBE_N,
  output wire logic              BACKEND_WRITE_STROBE_N,
  output wire logic [KIND_W-1:0] ACCESS_KIND_CODE,
  output wire logic [ADDR_W-1:0] BACKEND_ADDRESS,
  output wire logic [DATA_W-1:0] BACKEND_WRITE_WORD,
  input  wire logic [DATA_W-1:0] BACKEND_READ_WORD,
  input  wire logic              BACKEND_WAIT_N
);
  rtbp_state_t       st_r;
  rtbp_state_t       st_nxt;
  logic              mode_r;
  logic              mode_meta_r;
  logic              wr_r;
  logic              cs_n_r;
  logic              rd_n_r;
  logic              wrs_n_r;
  logic [KIND_W-1:0] kind_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdat_r;
  logic [DATA_W-1:0] rdat_r;
  logic              rval_r;
  logic [REQ_W-1:0]  f_word;
  logic              f_valid;

  // ****************************************************************
  // request buffering
  // ****************************************************************
  wire f_ready = (st_r == ST_IDLE);

  rtbp_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .in_data   ({REQ_WRITE, REQ_KIND, REQ_ADDR, REQ_DATA}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_word)
  );

  wire              f_wr   = f_word[REQ_WR_BIT];
  wire [KIND_W-1:0] f_kind = f_word[REQ_KIND_LSB +: KIND_W];
  wire [ADDR_W-1:0] f_addr = f_word[REQ_ADDR_LSB +: ADDR_W];
  wire [DATA_W-1:0] f_dat  = f_word[REQ_DATA_LSB +: DATA_W];
  wire              start  = f_valid && f_ready && (f_kind != KIND_UNUSED);
  wire              wr_nxt = start ? f_wr : wr_r;

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:  if (start) st_nxt = mode_r ? ST_SACC : ST_SETUP;
      ST_SETUP: st_nxt = ST_STRB;
      ST_STRB:  if (BACKEND_WAIT_N) st_nxt = ST_HOLD;
      ST_HOLD:  st_nxt = ST_IDLE;
      ST_SACC:  st_nxt = wr_r ? ST_IDLE : ST_SCAP;
      ST_SCAP:  st_nxt = ST_IDLE;
      default:  st_nxt = ST_IDLE;
    endcase
  end

  wire sel_nxt  = (st_nxt == ST_SETUP) || (st_nxt == ST_STRB) ||
                  (st_nxt == ST_HOLD) || (st_nxt == ST_SACC);
  wire strb_nxt = (st_nxt == ST_STRB) || (st_nxt == ST_SACC);
  // data sampled as the async strobe rises, or one edge after sync strobe
  wire capture  = (!wr_r && (st_r == ST_STRB) && BACKEND_WAIT_N) ||
                  (st_r == ST_SCAP);

  always_ff @(posedge CLK)
  begin
    mode_meta_r <= SYNC_MODE;
    if (RST)
      mode_r <= mode_meta_r;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_r    <= ST_IDLE;
      wr_r    <= 1'b0;
      cs_n_r  <= 1'b1;
      rd_n_r  <= 1'b1;
      wrs_n_r <= 1'b1;
      rval_r  <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      wr_r    <= wr_nxt;
      cs_n_r  <= !sel_nxt;
      rd_n_r  <= !(strb_nxt && !wr_nxt);
      wrs_n_r <= !(strb_nxt && wr_nxt);
      rval_r  <= capture;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      kind_r <= KIND_DATA;
      addr_r <= ADDR_RST;
      wdat_r <= DATA_RST;
      rdat_r <= DATA_RST;
    end
    else
    begin
      if (start)
      begin
        kind_r <= f_kind;
        addr_r <= f_addr;
        wdat_r <= f_dat;
      end
      if (capture)
        rdat_r <= BACKEND_READ_WORD;
    end
  end

  assign BACKEND_SELECT_N       = cs_n_r;
  assign BACKEND_READ_STROBE_N  = rd_n_r;
  assign BACKEND_WRITE_STROBE_N = wrs_n_r;
  assign ACCESS_KIND_CODE       = kind_r;
  assign BACKEND_ADDRESS        = addr_r;
  assign BACKEND_WRITE_WORD     = wdat_r;
  assign RD_DATA                = rdat_r;
  assign RD_VALID               = rval_r;
  assign BUSY                   = (st_r != ST_IDLE);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  wire strobe_n = rd_n_r && wrs_n_r;

  sequence s_async_setup;
    !cs_n_r && strobe_n;
  endsequence

  sequence s_async_hold;
    !cs_n_r && strobe_n ##1 cs_n_r;
  endsequence

  property p_sel_frames_addr;
    !cs_n_r && !$past(cs_n_r) |-> $stable(addr_r) && $stable(kind_r);
  endproperty
  a_sel_frames_addr: assert property (p_sel_frames_addr)
    else $error("address moved while select held");

  property p_wait_stretch;
    !mode_r && !strobe_n && !BACKEND_WAIT_N |=> !strobe_n && !cs_n_r;
  endproperty
  a_wait_stretch: assert property (p_wait_stretch)
    else $error("strobe released while wait low");

  property p_kind_legal;
    !cs_n_r |-> kind_r != KIND_UNUSED;
  endproperty
  a_kind_legal: assert property (p_kind_legal)
    else $error("unused access kind driven");

  property p_async_setup;
    !mode_r && $fell(strobe_n) |-> !$past(cs_n_r) && $past(strobe_n);
  endproperty
  a_async_setup: assert property (p_async_setup)
    else $error("async strobe without setup clock");

  property p_async_release;
    !mode_r && $rose(strobe_n) && !$past(cs_n_r) |-> s_async_hold;
  endproperty
  a_async_release: assert property (p_async_release)
    else $error("async address not held after strobe");

  property p_async_read_sample;
    !mode_r && !rd_n_r && BACKEND_WAIT_N |=> rval_r && rd_n_r;
  endproperty
  a_async_read_sample: assert property (p_async_read_sample)
    else $error("async read not sampled at strobe rise");

  property p_sync_read;
    mode_r && !rd_n_r |-> !cs_n_r ##1 rd_n_r ##1 rval_r;
  endproperty
  a_sync_read: assert property (p_sync_read)
    else $error("sync read not captured on next edge");

  property p_mode_fixed;
    $stable(mode_r);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("memory mode changed in operation");

  property p_async_entry;
    !mode_r && $fell(cs_n_r) |-> s_async_setup ##1 !strobe_n;
  endproperty
  a_async_entry: assert property (p_async_entry)
    else $error("async select not followed by strobe");
endmodule : rtbp_memport

// >>> verilog/rtbp_pkg.sv
// ****************************************************************
// backend memory port constants
// ****************************************************************
package rtbp_pkg;
  localparam int ADDR_W     = 11;
  localparam int DATA_W     = 16;
  localparam int KIND_W     = 2;
  localparam int FIFO_DEPTH = 16;

  // access kind codes
  localparam logic [KIND_W-1:0] KIND_DATA   = 2'h0;
  localparam logic [KIND_W-1:0] KIND_STATUS = 2'h1;
  localparam logic [KIND_W-1:0] KIND_CMD    = 2'h2;
  localparam logic [KIND_W-1:0] KIND_UNUSED = 2'h3;

  // request word layout inside the fifo
  localparam int REQ_DATA_LSB = 0;
  localparam int REQ_ADDR_LSB = REQ_DATA_LSB + DATA_W;
  localparam int REQ_KIND_LSB = REQ_ADDR_LSB + ADDR_W;
  localparam int REQ_WR_BIT   = REQ_KIND_LSB + KIND_W;
  localparam int REQ_W        = REQ_WR_BIT + 1;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'h01,
    ST_SETUP = 6'h02,
    ST_STRB  = 6'h04,
    ST_HOLD  = 6'h08,
    ST_SACC  = 6'h10,
    ST_SCAP  = 6'h20
  } rtbp_state_t;
endpackage : rtbp_pkg
